// ### rtl/olt_pkg.sv
// package for the low-speed threshold and first root hub descriptor bank
// assumes a 32-bit register port with one-cycle read latency
package olt_pkg;
  localparam logic [7:0] OLT_OFS_LS_THRESH = 8'h44;
  localparam logic [7:0] OLT_OFS_RH_DESC_A = 8'h48;
  localparam int OLT_THR_W = 12;
  localparam int OLT_FR_W = 14;
  localparam logic [11:0] OLT_THR_RST = 12'h628;
  // descriptor field positions
  localparam int OLT_POS_PGOOD = 24;
  localparam int OLT_POS_OC_UNSUP = 12;
  localparam int OLT_POS_OC_MODE = 11;
  localparam int OLT_POS_COMPOUND = 10;
  localparam int OLT_POS_ALWAYS_PWR = 9;
  localparam int OLT_POS_PSW_MODE = 8;
  localparam logic [7:0] OLT_PGOOD_RST = 8'hFF;
  localparam logic OLT_OC_UNSUP_RST = 1'b0;
  localparam logic OLT_ALWAYS_PWR_RST = 1'b0;
  localparam logic OLT_PSW_MODE_RST = 1'b1;
  localparam logic [7:0] OLT_PORT_COUNT = 8'h02;
  // power-good delay unit
  localparam int OLT_PGOOD_UNIT_MS = 2;
endpackage : olt_pkg

// ### rtl/olt_regs.sv
// register bank: low-speed commit threshold and first root hub descriptor
// assumes a plain register port and a frame remaining count from frame timing
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module olt_regs (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [31:0] RDATA,
  input wire logic [13:0] FRAME_TIME_REMAINING,
  input wire logic LS_START_REQ,
  output logic LS_START_OK,
  output logic [7:0] POWER_GOOD_DELAY,
  output logic OC_REPORTING,
  output logic OC_PER_PORT,
  output logic PWR_PER_PORT,
  output logic ALWAYS_POWERED
);
  logic [11:0] thr_ff;
  logic [7:0] pgood_ff;
  logic oc_unsup_ff;
  logic oc_mode_ff;
  logic always_pwr_ff;
  logic psw_mode_ff;
  logic [31:0] rdata_ff;
  wire sel_thr = (ADDR == olt_pkg::OLT_OFS_LS_THRESH);
  wire sel_desc = (ADDR == olt_pkg::OLT_OFS_RH_DESC_A);
  wire wr_thr = WR_STB && sel_thr;
  wire wr_desc = WR_STB && sel_desc;
  wire [31:0] thr_word = {20'h00000, thr_ff};
  // compound device bit and port count are constants, never stored
  wire [31:0] desc_word = {pgood_ff, 11'h000, oc_unsup_ff, oc_mode_ff, 1'b0,
                           always_pwr_ff, psw_mode_ff, olt_pkg::OLT_PORT_COUNT};
  wire [31:0] nxt_rdata = !RD_STB ? 32'h00000000 :
                          sel_thr ? thr_word :
                          sel_desc ? desc_word : 32'h00000000;
  // full 14-bit compare so large remaining counts never wrap past the threshold
  wire fits = ({2'b00, thr_ff} <= FRAME_TIME_REMAINING);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      thr_ff <= olt_pkg::OLT_THR_RST;
    end else if (wr_thr) begin
      thr_ff <= WDATA[11:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pgood_ff <= olt_pkg::OLT_PGOOD_RST;
      oc_unsup_ff <= olt_pkg::OLT_OC_UNSUP_RST;
      oc_mode_ff <= olt_pkg::OLT_PSW_MODE_RST;
      always_pwr_ff <= olt_pkg::OLT_ALWAYS_PWR_RST;
      psw_mode_ff <= olt_pkg::OLT_PSW_MODE_RST;
    end else if (wr_desc) begin
      pgood_ff <= WDATA[olt_pkg::OLT_POS_PGOOD +: 8];
      oc_unsup_ff <= WDATA[olt_pkg::OLT_POS_OC_UNSUP];
      oc_mode_ff <= WDATA[olt_pkg::OLT_POS_OC_MODE];
      always_pwr_ff <= WDATA[olt_pkg::OLT_POS_ALWAYS_PWR];
      psw_mode_ff <= WDATA[olt_pkg::OLT_POS_PSW_MODE];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;
  assign LS_START_OK = LS_START_REQ && fits;
  assign POWER_GOOD_DELAY = pgood_ff;
  assign OC_REPORTING = !oc_unsup_ff;
  assign OC_PER_PORT = !oc_unsup_ff && oc_mode_ff;
  // power switching mode only counts when ports are switched at all
  assign PWR_PER_PORT = !always_pwr_ff && psw_mode_ff;
  assign ALWAYS_POWERED = always_pwr_ff;

  // decoded strobes and the widened threshold, shared by the checks below;
  // kept apart from the datapath, though they and the checks still reuse its address selects and write strobes
  wire rd_thr = RD_STB && sel_thr;
  wire rd_desc = RD_STB && sel_desc;
  wire rd_none = RD_STB && !sel_thr && !sel_desc;
  wire wr_none = WR_STB && !sel_thr && !sel_desc;
  wire [13:0] thr_ext = {2'b00, thr_ff};

  // checks split by behaviour; several, such as AST_PWR_WR and AST_DESC_HOLD, cover more than one bit group

  AST_LS_GATE: assert property (
    @(posedge CLK) disable iff (SRST)
    LS_START_OK
    |-> (thr_ext <= FRAME_TIME_REMAINING))
    else $error("low-speed start granted below threshold");

  AST_LS_ALLOW: assert property (
    @(posedge CLK) disable iff (SRST)
    (LS_START_REQ && FRAME_TIME_REMAINING >= thr_ext)
    |-> LS_START_OK)
    else $error("low-speed start refused with enough frame time");

  AST_LS_IDLE: assert property (
    @(posedge CLK) disable iff (SRST)
    !LS_START_REQ
    |-> !LS_START_OK)
    else $error("low-speed start granted without a request");

  AST_LS_SHORT: assert property (
    @(posedge CLK) disable iff (SRST)
    (LS_START_REQ && FRAME_TIME_REMAINING < thr_ext)
    |-> !LS_START_OK)
    else $error("low-speed start granted with too little frame time");

  AST_LS_EQUAL: assert property (
    @(posedge CLK) disable iff (SRST)
    (LS_START_REQ && FRAME_TIME_REMAINING == thr_ext)
    |-> LS_START_OK)
    else $error("low-speed start refused at exactly the threshold");

  AST_THR_WRITE: assert property (
    @(posedge CLK) disable iff (SRST)
    wr_thr
    |=> (thr_ff == $past(WDATA[11:0])))
    else $error("threshold write not stored");

  AST_THR_HOLD: assert property (
    @(posedge CLK) disable iff (SRST)
    !wr_thr
    |=> $stable(thr_ff))
    else $error("threshold changed without a write");

  AST_THR_RD: assert property (
    @(posedge CLK) disable iff (SRST)
    rd_thr
    |=> (RDATA[11:0] == $past(thr_ff)))
    else $error("threshold read back wrong");

  AST_THR_RSV: assert property (
    @(posedge CLK) disable iff (SRST)
    rd_thr
    |=> (RDATA[31:12] == 20'h00000))
    else $error("threshold reserved bits not zero");

  AST_THR_NOT_DESC: assert property (
    @(posedge CLK) disable iff (SRST)
    wr_desc
    |=> $stable(thr_ff))
    else $error("descriptor write disturbed the threshold");

  AST_WR_UNMAPPED: assert property (
    @(posedge CLK) disable iff (SRST)
    wr_none
    |=> ($stable(thr_ff) && $stable(pgood_ff) && $stable(oc_mode_ff)))
    else $error("unmapped write changed a register");

  AST_RD_IDLE: assert property (
    @(posedge CLK) disable iff (SRST)
    !RD_STB
    |=> (RDATA == 32'h00000000))
    else $error("read data not zero outside the read cycle");

  AST_RD_UNMAPPED: assert property (
    @(posedge CLK) disable iff (SRST)
    rd_none
    |=> (RDATA == 32'h00000000))
    else $error("unmapped read returned data");

  AST_PGOOD: assert property (
    @(posedge CLK) disable iff (SRST)
    wr_desc
    |=> (POWER_GOOD_DELAY == $past(WDATA[31:24])))
    else $error("power-good delay not updated");

  AST_DESC_HOLD: assert property (
    @(posedge CLK) disable iff (SRST)
    !wr_desc
    |=> ($stable(pgood_ff) && $stable(oc_unsup_ff) && $stable(psw_mode_ff)))
    else $error("descriptor changed without a write");

  AST_OC_UNSUP_WR: assert property (
    @(posedge CLK) disable iff (SRST)
    wr_desc
    |=> (oc_unsup_ff == $past(WDATA[12])))
    else $error("overcurrent-unsupported bit not stored");

  AST_OC_MODE_WR: assert property (
    @(posedge CLK) disable iff (SRST)
    wr_desc
    |=> (oc_mode_ff == $past(WDATA[11])))
    else $error("report mode bit not stored");

  AST_PWR_WR: assert property (
    @(posedge CLK) disable iff (SRST)
    wr_desc
    |=> (always_pwr_ff == $past(WDATA[9]) && psw_mode_ff == $past(WDATA[8])))
    else $error("power switching bits not stored");

  AST_OC_NONE: assert property (
    @(posedge CLK) disable iff (SRST)
    oc_unsup_ff
    |-> (!OC_REPORTING && !OC_PER_PORT))
    else $error("overcurrent reported while unsupported");

  AST_OC_REP: assert property (
    @(posedge CLK) disable iff (SRST)
    !oc_unsup_ff
    |-> OC_REPORTING)
    else $error("overcurrent not reported while supported");

  AST_OC_COLLECT: assert property (
    @(posedge CLK) disable iff (SRST)
    (!oc_unsup_ff && !oc_mode_ff)
    |-> (OC_REPORTING && !OC_PER_PORT))
    else $error("collective reporting not selected");

  AST_OC_MODE: assert property (
    @(posedge CLK) disable iff (SRST)
    !oc_unsup_ff
    |-> (OC_PER_PORT == oc_mode_ff))
    else $error("overcurrent report mode mismatch");

  AST_OC_RESET: assert property (
    @(posedge CLK)
    SRST
    |=> (oc_mode_ff == psw_mode_ff))
    else $error("report mode differs from switching mode after reset");

  AST_RST_VALUES: assert property (
    @(posedge CLK)
    SRST
    |=> (thr_ff == olt_pkg::OLT_THR_RST && pgood_ff == olt_pkg::OLT_PGOOD_RST))
    else $error("register reset value wrong");

  AST_PWR_MODE: assert property (
    @(posedge CLK) disable iff (SRST)
    !always_pwr_ff
    |-> (PWR_PER_PORT == psw_mode_ff))
    else $error("power switching granularity wrong");

  AST_PWR_GANG: assert property (
    @(posedge CLK) disable iff (SRST)
    (!always_pwr_ff && !psw_mode_ff)
    |-> !PWR_PER_PORT)
    else $error("ganged power shown as per port");

  AST_PWR_ALWAYS: assert property (
    @(posedge CLK) disable iff (SRST)
    always_pwr_ff
    |-> (ALWAYS_POWERED && !PWR_PER_PORT))
    else $error("always-powered ports shown as switched");

  AST_DESC_RO: assert property (
    @(posedge CLK) disable iff (SRST)
    rd_desc
    |=> (RDATA[10] == 1'b0 && RDATA[7:0] == 8'h02))
    else $error("read-only descriptor fields wrong");

  AST_DESC_RSV: assert property (
    @(posedge CLK) disable iff (SRST)
    rd_desc
    |=> (RDATA[23:13] == 11'h000))
    else $error("descriptor reserved bits not zero");

  AST_DESC_PGOOD_RD: assert property (
    @(posedge CLK) disable iff (SRST)
    rd_desc
    |=> (RDATA[31:24] == $past(pgood_ff)))
    else $error("power-good delay read back wrong");

  AST_DESC_FLAGS_RD: assert property (
    @(posedge CLK) disable iff (SRST)
    rd_desc
    |=> (RDATA[12:11] == $past({oc_unsup_ff, oc_mode_ff})))
    else $error("overcurrent bits read back wrong");

  // main scenarios: grant, refusal, write then read, per-port reporting, reset again
  COV_LS_OK: cover property (@(posedge CLK) LS_START_OK);
  COV_LS_REFUSED: cover property (@(posedge CLK) LS_START_REQ && !LS_START_OK);
  COV_DESC_WR: cover property (@(posedge CLK) wr_desc ##1 rd_desc);
  COV_OC_PORT: cover property (@(posedge CLK) OC_PER_PORT);
  COV_RST_AGAIN: cover property (@(posedge CLK) !SRST ##1 SRST);
endmodule : olt_regs

// ### verif/olt_regs_tb.sv
// self-checking bench for the threshold and root hub descriptor bank
// assumes olt_regs on one 250 MHz clock with a synchronous reset
`timescale 1ns/10ps
module olt_regs_tb;
  logic clk = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, ls_req = 1'b0;
  logic [7:0] addr = 8'h00, pgood;
  logic [31:0] wdata = 32'h0, rdata;
  logic [13:0] fr = 14'h0;
  logic ok, oc_rep, oc_pp, pwr_pp, apwr;
  int error_cnt = 0, checks = 0;
  olt_regs olt_regs_i (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .FRAME_TIME_REMAINING(fr), .LS_START_REQ(ls_req),
    .LS_START_OK(ok), .POWER_GOOD_DELAY(pgood), .OC_REPORTING(oc_rep), .OC_PER_PORT(oc_pp),
    .PWR_PER_PORT(pwr_pp), .ALWAYS_POWERED(apwr));
  initial begin
    forever #2 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // read data is only valid in the cycle after the strobe, so sample it there
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task ls(input logic [13:0] f, input logic r, input logic exp);
    @(posedge clk);
    fr <= f;
    ls_req <= r;
    #1 chk(ok, exp);
  endtask : ls
  task t_reset;
    rd(olt_pkg::OLT_OFS_LS_THRESH, 32'h00000628);
    rd(olt_pkg::OLT_OFS_RH_DESC_A, 32'hFF000902);
    chk({pgood, oc_rep, oc_pp, pwr_pp, apwr}, {8'hFF, 4'hE});
  endtask : t_reset
  task t_thresh;
    wr(olt_pkg::OLT_OFS_LS_THRESH, 32'h00000010);
    rd(olt_pkg::OLT_OFS_LS_THRESH, 32'h00000010);
    ls(14'h0010, 1'b1, 1'b1);
    ls(14'h000F, 1'b1, 1'b0);
    ls(14'h3FFF, 1'b0, 1'b0);
  endtask : t_thresh
  task t_desc;
    // consecutive writes with an idle cycle between, the unmapped one must leave both registers alone
    wr(olt_pkg::OLT_OFS_RH_DESC_A, 32'h12001B00);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    rd(olt_pkg::OLT_OFS_RH_DESC_A, 32'h12001B02);
    chk({pgood, oc_rep, oc_pp, pwr_pp, apwr}, {8'h12, 4'h1});
    chk(pgood, 8'h12);
    wr(olt_pkg::OLT_OFS_RH_DESC_A, 32'h00000800);
    rd(olt_pkg::OLT_OFS_RH_DESC_A, 32'h00000802);
    chk({pgood, oc_rep, oc_pp, pwr_pp, apwr}, {8'h00, 4'hC});
    rd(olt_pkg::OLT_OFS_LS_THRESH, 32'h00000010);
  endtask : t_desc
  // reset in mid-run must bring the report mode back in step with switching mode
  task t_rerun;
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(olt_pkg::OLT_OFS_RH_DESC_A, 32'hFF000902);
    rd(olt_pkg::OLT_OFS_LS_THRESH, 32'h00000628);
  endtask : t_rerun
  task test_done;
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_thresh();
    t_desc();
    t_rerun();
    test_done();
  end
endmodule : olt_regs_tb
